// ===== hdl/t2cc_capture_input.sv
`timescale 1ns/1ps
`default_nettype none

module t2cc_capture_input (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   pin,
  input  wire t2cc_pkg::t2cc_cap_cfg_s cfg,
  output var  logic                   capture_pulse
);
  import t2cc_pkg::*;

  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  filt_level_reg;
  logic                  filt_level_next;
  logic [FILT_CNT_W-1:0] filt_cnt_reg;
  logic [FILT_CNT_W-1:0] filt_cnt_next;
  logic                  prev_level_reg;
  logic                  level;
  logic                  rise;
  logic                  fall;
  logic                  pulse_next;

  // ****************************************************************
  // Synchroniser, pin is asynchronous to clk
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // Glitch filter
  // ****************************************************************
  // A new level is accepted only after it has held for the full filter time
  always_comb begin
    filt_level_next = filt_level_reg;
    filt_cnt_next   = '0;
    if (sync2_reg != filt_level_reg) begin
      if (filt_cnt_reg == FILT_CNT_W'(FILTER_CYCLES - 1)) begin
        filt_level_next = sync2_reg;
      end else begin
        filt_cnt_next = filt_cnt_reg + FILT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_level_reg <= 1'b0;
      filt_cnt_reg   <= '0;
    end else begin
      filt_level_reg <= filt_level_next;
      filt_cnt_reg   <= filt_cnt_next;
    end
  end

  // ****************************************************************
  // Edge detection and selection
  // ****************************************************************
  always_comb begin
    level = cfg.filt_en ? filt_level_reg : sync2_reg; // R10
    rise  = level & ~prev_level_reg;
    fall  = ~level & prev_level_reg;
    case (cfg.edge_sel)
      T2CC_EDGE_OFF:  pulse_next = 1'b0; // R05
      T2CC_EDGE_RISE: pulse_next = rise; // R06
      T2CC_EDGE_FALL: pulse_next = fall; // R06
      T2CC_EDGE_BOTH: pulse_next = rise | fall; // R06
      default:        pulse_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_level_reg <= 1'b0;
      capture_pulse  <= 1'b0;
    end else begin
      prev_level_reg <= level;
      capture_pulse  <= pulse_next;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/t2cc_pkg.sv
`default_nettype none
package t2cc_pkg;

  // ****************************************************************
  // Widths and basic types
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;

  typedef logic [DATA_W-1:0] t2cc_word_t;
  typedef logic [ADDR_W-1:0] t2cc_addr_t;

  localparam t2cc_word_t RESET_WORD = 16'h0000;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam t2cc_addr_t ADDR_CAP_A_VALUE  = 16'h4582;
  localparam t2cc_addr_t ADDR_CAP_B_VALUE  = 16'h4584;
  localparam t2cc_addr_t ADDR_MATCH_A      = 16'h4588;
  localparam t2cc_addr_t ADDR_MATCH_B      = 16'h458A;
  localparam t2cc_addr_t ADDR_CAP_A_SETUP  = 16'h4592;
  localparam t2cc_addr_t ADDR_CAP_B_SETUP  = 16'h4594;
  localparam t2cc_addr_t ADDR_IRQ_ENABLE   = 16'h462C;
  localparam t2cc_addr_t ADDR_IRQ_STATUS   = 16'h4630;
  localparam t2cc_addr_t ADDR_IRQ_CLEAR    = 16'h4632;

  // ****************************************************************
  // Capture setup fields
  // ****************************************************************
  localparam int CFG_FILT_BIT = 8;
  localparam int CFG_EDGE_LSB = 5;
  localparam int CFG_EDGE_MSB = 6;

  typedef enum logic [1:0] {
    T2CC_EDGE_OFF,
    T2CC_EDGE_RISE,
    T2CC_EDGE_FALL,
    T2CC_EDGE_BOTH
  } t2cc_edge_e;

  typedef struct packed {
    logic       filt_en;
    t2cc_edge_e edge_sel;
  } t2cc_cap_cfg_s;

  localparam t2cc_cap_cfg_s CAP_CFG_RESET = '{filt_en: 1'b0, edge_sel: T2CC_EDGE_OFF};

  // ****************************************************************
  // Interrupt enable / status layout
  // ****************************************************************
  localparam int IRQ_T2_CAP_B  = 14;
  localparam int IRQ_T2_CAP_A  = 13;
  localparam int IRQ_T2_TOP    = 12;
  localparam int IRQ_T2_ZERO   = 11;
  localparam int IRQ_T2_CMP_B  = 10;
  localparam int IRQ_T2_CMP_A  = 9;
  localparam int IRQ_T2_WRAP   = 8;
  localparam int IRQ_T1_LSB    = 0;
  localparam int IRQ_T1_W      = 7;

  localparam t2cc_word_t IRQ_VALID_MASK = 16'h7F7F;

  // ****************************************************************
  // Capture channels
  // ****************************************************************
  localparam int NUM_CH = 2;
  localparam int CH_A   = 0;
  localparam int CH_B   = 1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FILTER_TIME_NS = 40;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W     = 3;

  // ****************************************************************
  // Register port request
  // ****************************************************************
  typedef struct packed {
    t2cc_addr_t addr;
    t2cc_word_t wdata;
    logic       wr;
    logic       rd;
  } t2cc_bus_req_s;

endpackage
`default_nettype wire

// ===== hdl/t2cc_regs.sv
// Notes on behaviour
// R01 - Compare-A value register, read/write, cleared at reset, matched against count.
// R02 - Compare-B value register, read/write, cleared at reset, makes compare-B match.
// R03 - Capture-A register is read-only, holds count at last qualifying A edge.
// R04 - Capture-B register is read-only, holds count at last qualifying B edge.
// R05 - Edge-select zero disables capture and its capture event.
// R06 - Edge-select one rising, two falling, three both edges.
// R07 - Enable bit 12 gates the timer-two reach-threshold event onto the interrupt.
// R08 - Enable bit 11 gates the timer-two reach-zero event onto the interrupt.
// R09 - Captures latch timer two's current sixteen-bit running count.
// R10 - Setup bit 8 routes input through glitch filter; other non-edge bits read zero.
// R11 - Enable layout: t2 bits 14,13,12,11,10,9,8; t1 bits 6..0; bits 15,7 zero.
`timescale 1ns/1ps
`default_nettype none

module t2cc_regs (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire t2cc_pkg::t2cc_bus_req_s bus_req,
  output var  t2cc_pkg::t2cc_word_t   rd_data,
  input  wire t2cc_pkg::t2cc_word_t   timer2_running_count,
  input  wire logic                   t2_reach_threshold_evt,
  input  wire logic                   t2_reach_zero_evt,
  input  wire logic                   t2_overflow_evt,
  input  wire logic [6:0]             t1_event,
  input  wire logic                   cap_pin_a,
  input  wire logic                   cap_pin_b,
  output var  logic                   t2_match_a_evt,
  output var  logic                   t2_match_b_evt,
  output var  logic                   t2_capture_a_evt,
  output var  logic                   t2_capture_b_evt,
  output var  logic                   irq
);
  import t2cc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  t2cc_word_t    match_reg     [NUM_CH];
  t2cc_word_t    match_next    [NUM_CH];
  t2cc_word_t    cap_val_reg   [NUM_CH];
  t2cc_word_t    cap_val_next  [NUM_CH];
  t2cc_cap_cfg_s cfg_reg       [NUM_CH];
  t2cc_cap_cfg_s cfg_next      [NUM_CH];
  logic          cap_pulse     [NUM_CH];
  logic          eq_prev_reg   [NUM_CH];
  logic          eq_now        [NUM_CH];
  logic          match_pulse   [NUM_CH];
  logic          cap_pin       [NUM_CH];

  t2cc_word_t    irq_en_reg;
  t2cc_word_t    irq_en_next;
  t2cc_word_t    irq_stat_reg;
  t2cc_word_t    irq_stat_next;
  t2cc_word_t    irq_events;
  logic          irq_next;

  t2cc_word_t    rd_data_next;
  logic          wr_match      [NUM_CH];
  logic          wr_setup      [NUM_CH];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit(input t2cc_bus_req_s req, input t2cc_addr_t where);
    hit = (req.addr == where);
  endfunction

  // Only the filter and edge fields exist; all other bits read zero
  function automatic t2cc_word_t pack_cfg(input t2cc_cap_cfg_s c);
    t2cc_word_t w;
    w = RESET_WORD;
    w[CFG_FILT_BIT] = c.filt_en; // R10
    w[CFG_EDGE_MSB:CFG_EDGE_LSB] = c.edge_sel;
    pack_cfg = w;
  endfunction

  function automatic t2cc_cap_cfg_s unpack_cfg(input t2cc_word_t w);
    t2cc_cap_cfg_s c;
    c.filt_en  = w[CFG_FILT_BIT];
    c.edge_sel = t2cc_edge_e'(w[CFG_EDGE_MSB:CFG_EDGE_LSB]);
    unpack_cfg = c;
  endfunction

  assign cap_pin[CH_A] = cap_pin_a;
  assign cap_pin[CH_B] = cap_pin_b;

  assign wr_match[CH_A] = bus_req.wr && hit(bus_req, ADDR_MATCH_A);
  assign wr_match[CH_B] = bus_req.wr && hit(bus_req, ADDR_MATCH_B);
  assign wr_setup[CH_A] = bus_req.wr && hit(bus_req, ADDR_CAP_A_SETUP);
  assign wr_setup[CH_B] = bus_req.wr && hit(bus_req, ADDR_CAP_B_SETUP);

  // ****************************************************************
  // Per-channel compare and capture
  // ****************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      t2cc_capture_input u_cap (
        .clk           (clk),
        .rst           (rst),
        .pin           (cap_pin[ch]),
        .cfg           (cfg_reg[ch]),
        .capture_pulse (cap_pulse[ch])
      );

      // A match is reported once, when the count first equals the value
      always_comb begin
        eq_now[ch]      = (timer2_running_count == match_reg[ch]); // R01 R02
        match_pulse[ch] = eq_now[ch] & ~eq_prev_reg[ch];
        match_next[ch]  = wr_match[ch] ? bus_req.wdata : match_reg[ch]; // R01 R02
        cfg_next[ch]    = wr_setup[ch] ? unpack_cfg(bus_req.wdata) : cfg_reg[ch];
        // Capture registers ignore software writes
        cap_val_next[ch] = cap_pulse[ch] ? timer2_running_count : cap_val_reg[ch]; // R03 R04 R09
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          match_reg[ch]   <= RESET_WORD;
          cap_val_reg[ch] <= RESET_WORD;
          cfg_reg[ch]     <= CAP_CFG_RESET;
          eq_prev_reg[ch] <= 1'b0;
        end else begin
          match_reg[ch]   <= match_next[ch];
          cap_val_reg[ch] <= cap_val_next[ch];
          cfg_reg[ch]     <= cfg_next[ch];
          eq_prev_reg[ch] <= eq_now[ch];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Event outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      t2_match_a_evt   <= 1'b0;
      t2_match_b_evt   <= 1'b0;
      t2_capture_a_evt <= 1'b0;
      t2_capture_b_evt <= 1'b0;
    end else begin
      t2_match_a_evt   <= match_pulse[CH_A];
      t2_match_b_evt   <= match_pulse[CH_B];
      t2_capture_a_evt <= cap_pulse[CH_A];
      t2_capture_b_evt <= cap_pulse[CH_B];
    end
  end

  // ****************************************************************
  // Interrupt enable, status and output
  // ****************************************************************
  always_comb begin
    irq_events = RESET_WORD;
    irq_events[IRQ_T2_CAP_B] = cap_pulse[CH_B];
    irq_events[IRQ_T2_CAP_A] = cap_pulse[CH_A];
    irq_events[IRQ_T2_TOP]   = t2_reach_threshold_evt;
    irq_events[IRQ_T2_ZERO]  = t2_reach_zero_evt;
    irq_events[IRQ_T2_CMP_B] = match_pulse[CH_B];
    irq_events[IRQ_T2_CMP_A] = match_pulse[CH_A];
    irq_events[IRQ_T2_WRAP]  = t2_overflow_evt;
    irq_events[IRQ_T1_LSB +: IRQ_T1_W] = t1_event;
  end

  always_comb begin
    irq_en_next = irq_en_reg;
    if (bus_req.wr && hit(bus_req, ADDR_IRQ_ENABLE)) begin
      irq_en_next = bus_req.wdata & IRQ_VALID_MASK; // R11
    end
    irq_stat_next = irq_stat_reg;
    if (bus_req.wr && hit(bus_req, ADDR_IRQ_CLEAR)) begin
      irq_stat_next = irq_stat_reg & ~bus_req.wdata;
    end
    // Set after clear so a same-cycle event survives the clear
    irq_stat_next = (irq_stat_next | irq_events) & IRQ_VALID_MASK;
    // Top and zero use bits 12 and 11, like every other event bit
    irq_next = |(irq_stat_next & irq_en_next); // R07 R08
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg   <= RESET_WORD;
      irq_stat_reg <= RESET_WORD;
      irq          <= 1'b0;
    end else begin
      irq_en_reg   <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
      irq          <= irq_next;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Unmapped offsets and the write-only clear register read zero
  always_comb begin
    rd_data_next = RESET_WORD;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CAP_A_VALUE: rd_data_next = cap_val_reg[CH_A]; // R03
        ADDR_CAP_B_VALUE: rd_data_next = cap_val_reg[CH_B]; // R04
        ADDR_MATCH_A:     rd_data_next = match_reg[CH_A];
        ADDR_MATCH_B:     rd_data_next = match_reg[CH_B];
        ADDR_CAP_A_SETUP: rd_data_next = pack_cfg(cfg_reg[CH_A]);
        ADDR_CAP_B_SETUP: rd_data_next = pack_cfg(cfg_reg[CH_B]);
        ADDR_IRQ_ENABLE:  rd_data_next = irq_en_reg;
        ADDR_IRQ_STATUS:  rd_data_next = irq_stat_reg;
        default:          rd_data_next = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= RESET_WORD;
    end else begin
      rd_data <= rd_data_next;
    end
  end

endmodule

`default_nettype wire

// ===== test/t2cc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module t2cc_pin_model (
  input  wire logic clk,
  output var  logic pin_a,
  output var  logic pin_b
);
  // ****
  // Capture pins, idle low so reset release shows no edge
  // ****
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Hold a level on one pin for a number of cycles; short holds make glitches
  task automatic drive(input logic ch, input logic lvl, input int cycles);
    if (ch) begin
      pin_b <= lvl;
    end else begin
      pin_a <= lvl;
    end
    repeat (cycles) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== test/t2cc_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module t2cc_regs_checker (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire t2cc_pkg::t2cc_bus_req_s bus_req,
  input wire t2cc_pkg::t2cc_word_t    rd_data,
  input wire logic                    cap_pin_a,
  input wire logic                    t2_match_a_evt,
  input wire logic                    t2_capture_a_evt,
  input wire logic                    irq
);
  import t2cc_pkg::*;
  wire logic       w = bus_req.wr;
  wire logic       r = bus_req.rd;
  wire t2cc_addr_t a = bus_req.addr;
  wire t2cc_word_t d = bus_req.wdata;
  logic [3:0]      age;
  logic            pin_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Age of pin A level; even the filtered path must answer well inside it
  // ****
  always_ff @(posedge clk) begin
    pin_q <= cap_pin_a;
    if (rst || cap_pin_a != pin_q) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end
  property p_rd_idle;
    !r |=> rd_data == RESET_WORD;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_ma_rw;
    (w && a == ADDR_MATCH_A) ##1 (r && a == ADDR_MATCH_A) |=> rd_data == $past(d, 2);
  endproperty
  a_ma_rw: assert property (p_ma_rw)
    else $error("match A readback wrong");
  property p_en_rw;
    (w && a == ADDR_IRQ_ENABLE) ##1 (r && a == ADDR_IRQ_ENABLE)
      |=> rd_data == ($past(d, 2) & IRQ_VALID_MASK);
  endproperty
  a_en_rw: assert property (p_en_rw)
    else $error("enable readback wrong");
  property p_setup_rw;
    (w && a == ADDR_CAP_B_SETUP) ##1 (r && a == ADDR_CAP_B_SETUP)
      |=> rd_data == ($past(d, 2) & 16'h0160);
  endproperty
  a_setup_rw: assert property (p_setup_rw)
    else $error("setup readback wrong");
  property p_cap_late;
    t2_capture_a_evt |-> age < 4'hD;
  endproperty
  a_cap_late: assert property (p_cap_late)
    else $error("capture without a recent pin edge");
  property p_ma_pulse;
    t2_match_a_evt |=> !t2_match_a_evt;
  endproperty
  a_ma_pulse: assert property (p_ma_pulse)
    else $error("match event longer than one cycle");
  property p_irq_off;
    (w && a == ADDR_IRQ_ENABLE && d == RESET_WORD) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables clear");
  property p_rst;
    disable iff (1'b0) rst |=> rd_data == RESET_WORD && !irq && !t2_capture_a_evt;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
endmodule
bind t2cc_regs t2cc_regs_checker t2cc_regs_checker_inst (
  .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .cap_pin_a(cap_pin_a),
  .t2_match_a_evt(t2_match_a_evt), .t2_capture_a_evt(t2_capture_a_evt), .irq(irq)
);
`default_nettype wire

// ===== test/tb_t2cc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_t2cc_regs;
  import t2cc_pkg::*;
  logic          clk;
  logic          rst;
  t2cc_bus_req_s q;
  t2cc_word_t    rd_data;
  t2cc_word_t    cnt;
  t2cc_word_t    ev;
  t2cc_word_t    v;
  t2cc_word_t    n_ma, n_mb, n_ca, n_cb;
  logic          pa, pb, ma, mb, ca, cb, irq;
  int            miscompares;
  int            samples_checked;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  t2cc_regs t2cc_regs_inst (
    .clk(clk), .rst(rst), .bus_req(q), .rd_data(rd_data), .timer2_running_count(cnt),
    .t2_reach_threshold_evt(ev[IRQ_T2_TOP]), .t2_reach_zero_evt(ev[IRQ_T2_ZERO]),
    .t2_overflow_evt(ev[IRQ_T2_WRAP]), .t1_event(ev[6:0]), .cap_pin_a(pa), .cap_pin_b(pb),
    .t2_match_a_evt(ma), .t2_match_b_evt(mb), .t2_capture_a_evt(ca),
    .t2_capture_b_evt(cb), .irq(irq)
  );
  t2cc_pin_model t2cc_pin_model_inst (.clk(clk), .pin_a(pa), .pin_b(pb));
  // ****
  // Bus and watch helpers end 1 ns after an edge; chk compares at once
  // ****
  task automatic chk(input t2cc_word_t got, input t2cc_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input t2cc_addr_t a, input t2cc_word_t d);
    q <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    q <= '0;
    #1;
  endtask
  task automatic rd(input t2cc_addr_t a, output t2cc_word_t d);
    q <= '{a, RESET_WORD, 1'b0, 1'b1};
    @(posedge clk);
    q <= '0;
    #1;
    d = rd_data;
  endtask
  task automatic watch(input int n);
    {n_ma, n_mb, n_ca, n_cb} = '0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_ma += ma;
      n_mb += mb;
      n_ca += ca;
      n_cb += cb;
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset_values();
    t2cc_addr_t m [7] = '{ADDR_CAP_A_VALUE, ADDR_CAP_B_VALUE, ADDR_MATCH_A, ADDR_MATCH_B,
                          ADDR_CAP_A_SETUP, ADDR_CAP_B_SETUP, ADDR_IRQ_ENABLE};
    foreach (m[i]) begin
      rd(m[i], v);
      chk(v, RESET_WORD);
    end
  endtask
  task automatic t_access();
    wr(ADDR_MATCH_A, 16'hFFFF);
    rd(ADDR_MATCH_A, v);
    chk(v, 16'hFFFF);
    wr(ADDR_MATCH_B, 16'h5A5A);
    rd(ADDR_MATCH_B, v);
    chk(v, 16'h5A5A);
    wr(ADDR_IRQ_ENABLE, 16'hFFFF);
    rd(ADDR_IRQ_ENABLE, v);
    chk(v, 16'h7F7F);
    wr(ADDR_CAP_B_SETUP, 16'hFFFF);
    rd(ADDR_CAP_B_SETUP, v);
    chk(v, 16'h0160);
    wr(ADDR_CAP_B_SETUP, RESET_WORD);
    wr(ADDR_IRQ_ENABLE, RESET_WORD);
    wr(ADDR_CAP_A_VALUE, 16'hBEEF);
    rd(ADDR_CAP_A_VALUE, v);
    chk(v, RESET_WORD);
    rd(16'h4600, v);
    chk(v, RESET_WORD);
  endtask
  task automatic t_match();
    // Count and match both zero at reset release already set the match bits
    wr(ADDR_IRQ_CLEAR, 16'hFFFF);
    cnt <= 16'h1234;
    wr(ADDR_MATCH_A, 16'h1234);
    watch(8);
    chk(n_ma, 16'h0001);
    chk(n_mb, 16'h0000);
    wr(ADDR_MATCH_B, 16'h1234);
    watch(8);
    chk(n_mb, 16'h0001);
    rd(ADDR_IRQ_STATUS, v);
    chk(v, 16'h0600);
  endtask
  task automatic t_edges();
    t2cc_word_t cap;
    cap = RESET_WORD;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CAP_A_SETUP, t2cc_word_t'(m << CFG_EDGE_LSB));
      for (int e = 0; e < 2; e++) begin
        cnt <= 16'h1000 + t2cc_word_t'(2 * m + e);
        t2cc_pin_model_inst.drive(1'b0, e == 0, 1);
        watch(16);
        chk(n_ca, t2cc_word_t'((m >> e) & 1));
        if (((m >> e) & 1) == 1) begin
          cap = 16'h1000 + t2cc_word_t'(2 * m + e);
        end
      end
      rd(ADDR_CAP_A_VALUE, v);
      chk(v, cap);
    end
  endtask
  task automatic t_filter();
    wr(ADDR_CAP_B_SETUP, 16'h0120);
    watch(16);
    cnt <= 16'h2222;
    t2cc_pin_model_inst.drive(1'b1, 1'b1, 2);
    t2cc_pin_model_inst.drive(1'b1, 1'b0, 1);
    watch(16);
    chk(n_cb, 16'h0000);
    cnt <= 16'h3333;
    t2cc_pin_model_inst.drive(1'b1, 1'b1, 1);
    watch(16);
    chk(n_cb, 16'h0001);
    rd(ADDR_CAP_B_VALUE, v);
    chk(v, 16'h3333);
  endtask
  task automatic t_irq();
    int b [4] = '{IRQ_T2_TOP, IRQ_T2_ZERO, IRQ_T2_WRAP, 3};
    foreach (b[i]) begin
      wr(ADDR_IRQ_ENABLE, RESET_WORD);
      wr(ADDR_IRQ_CLEAR, 16'hFFFF);
      ev <= 16'h0001 << b[i];
      @(posedge clk);
      ev <= '0;
      #1;
      chk({15'h0000, irq}, 16'h0000);
      rd(ADDR_IRQ_STATUS, v);
      chk(v, 16'h0001 << b[i]);
      wr(ADDR_IRQ_ENABLE, 16'h0001 << b[i]);
      chk({15'h0000, irq}, 16'h0001);
      wr(ADDR_IRQ_CLEAR, 16'h0001 << b[i]);
      chk({15'h0000, irq}, 16'h0000);
    end
  endtask
  task automatic t_mid_reset();
    wr(ADDR_MATCH_A, 16'hAAAA);
    wr(ADDR_IRQ_ENABLE, 16'h7F7F);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd(ADDR_MATCH_A, v);
    chk(v, RESET_WORD);
    rd(ADDR_IRQ_ENABLE, v);
    chk(v, RESET_WORD);
    rd(ADDR_CAP_A_SETUP, v);
    chk(v, RESET_WORD);
    rd(ADDR_CAP_A_VALUE, v);
    chk(v, RESET_WORD);
    rd(ADDR_IRQ_STATUS, v);
    chk(v, RESET_WORD);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'b1;
    q = '0;
    cnt = '0;
    ev = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset_values();
    t_access();
    t_match();
    t_edges();
    t_filter();
    t_irq();
    t_mid_reset();
    stop_test();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
